/* File: core/ssc_map.svh */
// constant map for the scan, settle and chop sequencer
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH
`define SSC_UNIT_CLKS 16'h0080
`define SSC_OVH_CLKS 16'h0222
`define SSC_NCH 16'h0010
`define SSC_DATA_W 16'h0018
`define SSC_CNT_W 16'h0010
`define SSC_DLY_U0 6'h00
`define SSC_DLY_U1 6'h01
`define SSC_DLY_U2 6'h02
`define SSC_DLY_U3 6'h04
`define SSC_DLY_U4 6'h08
`define SSC_DLY_U5 6'h10
`define SSC_DLY_U6 6'h20
`define SSC_DLY_U7 6'h30
`endif

/* File: core/ssc_pkg.sv */
// types shared by the scan, settle and chop sequencer
package ssc_pkg;
	typedef struct packed {
		logic auto_scan;
		logic pulse_mode;
		logic ext_chop_enable;
		logic loop_bypass_sel;
		logic bias_enable;
		logic bias_high;
		logic [2:0] switch_delay_code;
		logic [1:0] rate_select;
	} ssc_cfg_s;

	typedef struct packed {
		logic [23:0] data;
		logic [3:0] chan;
	} ssc_result_s;

	typedef enum logic [3:0] {
		ssc_idle = 4'b0001,
		ssc_settle = 4'b0010,
		ssc_conv = 4'b0100,
		ssc_post = 4'b1000
	} ssc_state_e;
endpackage : ssc_pkg

/* File: core/ssc_settle_timer.sv */
// down counter for settle and overhead waits
`timescale 1ns/100ps
module ssc_settle_timer #(
	parameter int CNT_W = 16
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_load,
	input wire logic [CNT_W-1:0] i_count,
	output logic o_busy,
	output logic o_expire
);
	logic [CNT_W-1:0] cnt;
	wire logic at_one;

	assign at_one = (cnt == CNT_W'(1));
	assign o_busy = (cnt != '0);
	// expire marks the last counted cycle
	assign o_expire = i_ce && at_one;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt <= '0;
		end else if (i_ce) begin
			if (i_load) begin
				cnt <= i_count;
			end else if (o_busy) begin
				cnt <= cnt - CNT_W'(1);
			end
		end
	end
endmodule : ssc_settle_timer

/* File: core/ssc_sequencer.sv */
// conversion sequencer: channel switch, settle delay, external chop
// Operation
// [RL1] delay code 0..7 gives 0,1,2,4,8,16,32,48 units of 128 clocks
// [RL2] auto scan waits the programmed delay after each channel switch
// [RL3] a non-zero delay lengthens every channel conversion period; fixed mode without chop adds no wait
// [RL4] chop takes two readings of one channel, second with swapped inputs
// [RL5] chop result is the average of both opposite-polarity readings
// [RL6] chop gives one result per two conversions, half the rate
// [RL7] device swaps polarity itself and settles before second phase
// [RL8] host must clear chop before any internal monitor reading
// [RL9] bypass select 0 routes mux output straight to converter input
// [RL10] multiplexer output pins stay active whatever the bypass setting
// [RL11] bias is a pos-source, neg-sink pair of 1.5uA or 24uA
// [RL12] bias reaches only the selected channel through the mux output
// [RL13] pulse operation converts one channel per start pulse or command
// [RL14] host spaces pulses to settle, still programs delay for chop
// [RL15] host enables bias only periodically for open checks, drops data
// [RL16] host scans at 24uA then 1.5uA and subtracts for diode temp
// [RL17] fixed mode: delay and overhead only with chop; auto: always
// [RL18] data_ready_n goes low as each channel result becomes available
// [RL19] delay counter starts on switch or swap, conversion waits for it
// [RL20] delay code zero adds no wait cycles before the conversion
`timescale 1ns/100ps
`include "ssc_map.svh"
module ssc_sequencer #(
	parameter int NCH = `SSC_NCH,
	parameter int DATA_W = `SSC_DATA_W,
	parameter int CNT_W = `SSC_CNT_W,
	parameter int UNIT_CLKS = `SSC_UNIT_CLKS,
	parameter int OVH_CLKS = `SSC_OVH_CLKS
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire ssc_pkg::ssc_cfg_s i_cfg,
	input wire logic [NCH-1:0] i_scan_mask,
	input wire logic [3:0] i_fixed_chan,
	input wire logic i_start_pin,
	input wire logic i_pulse_cmd,
	input wire logic i_data_read,
	output logic o_conv_start,
	input wire logic i_conv_done,
	input wire logic [DATA_W-1:0] i_conv_data,
	output logic [3:0] o_mux_chan,
	output logic o_polarity_swap,
	output logic o_mux_out_en,
	output logic o_adc_internal,
	output logic o_bias_src_pos,
	output logic o_bias_sink_neg,
	output logic o_bias_high,
	output logic [1:0] o_rate_select,
	output ssc_pkg::ssc_result_s o_result,
	output logic o_data_ready_n,
	output logic o_busy
);
	import ssc_pkg::*;

	localparam logic [CNT_W-1:0] UNIT_W = CNT_W'(UNIT_CLKS);
	localparam logic [CNT_W-1:0] OVH_W = CNT_W'(OVH_CLKS);

	function automatic logic [5:0] dly_units(input logic [2:0] code);
		logic [5:0] u;
		u = `SSC_DLY_U0;
		case (code)
			3'h1: u = `SSC_DLY_U1;
			3'h2: u = `SSC_DLY_U2;
			3'h3: u = `SSC_DLY_U3;
			3'h4: u = `SSC_DLY_U4;
			3'h5: u = `SSC_DLY_U5;
			3'h6: u = `SSC_DLY_U6;
			3'h7: u = `SSC_DLY_U7;
			default: u = `SSC_DLY_U0;
		endcase
		return u;
	endfunction : dly_units

	// lowest enabled channel after the current one, wrapping
	function automatic logic [3:0] next_chan(input logic [3:0] cur,
			input logic [NCH-1:0] mask);
		logic [3:0] pick;
		logic found;
		int k;
		pick = cur;
		found = 1'b0;
		k = 0;
		for (int i = 1; i <= NCH; i++) begin
			k = (int'(cur) + i) % NCH;
			if (!found && mask[k]) begin
				pick = 4'(k);
				found = 1'b1;
			end
		end
		return pick;
	endfunction : next_chan

	ssc_state_e st;
	ssc_state_e next_st;
	logic sync1, sync2, sync3;
	logic start_lvl;
	logic chop_run;
	logic chop_phase;
	logic [DATA_W-1:0] first_read;
	logic data_ready_n_pend;

	wire logic start_rise;
	wire logic pulse_evt;
	wire logic want_run;
	wire logic launch;
	wire logic swap_evt;
	wire logic settle_go;
	wire logic res_fire;
	wire logic waits_apply;
	wire logic [CNT_W-1:0] wait_cnt;
	wire logic wait_zero;
	wire logic ovh_zero;
	wire logic tmr_load;
	wire logic [CNT_W-1:0] tmr_count;
	wire logic tmr_expire;
	wire logic [3:0] launch_chan;
	wire logic [DATA_W:0] chop_diff;
	wire logic [DATA_W-1:0] res_data;

	// pin input: three stages, a change counts once stages two and three agree
	assign start_rise = (sync2 == sync3) && sync3 && !start_lvl;
	assign pulse_evt = start_rise || i_pulse_cmd;
	assign want_run = i_cfg.pulse_mode ? pulse_evt : start_lvl; // RL13
	assign launch = i_ce && (st == ssc_idle) && want_run;
	assign swap_evt = i_ce && (st == ssc_conv) && i_conv_done
		&& chop_run && !chop_phase; // RL4 RL7
	assign settle_go = launch || swap_evt; // RL19
	assign res_fire = i_ce && (st == ssc_conv) && i_conv_done
		&& !(chop_run && !chop_phase);

	// fixed channel without chop skips both waits
	assign waits_apply = i_cfg.auto_scan
		|| (launch ? i_cfg.ext_chop_enable : chop_run); // RL17
	assign wait_cnt = waits_apply
		? CNT_W'(dly_units(i_cfg.switch_delay_code) * UNIT_W)
		: '0; // RL1 RL3
	assign wait_zero = (wait_cnt == '0); // RL20
	assign ovh_zero = !(i_cfg.auto_scan || chop_run); // RL17
	assign tmr_load = (settle_go && !wait_zero) || (res_fire && !ovh_zero);
	assign tmr_count = settle_go ? wait_cnt : OVH_W;

	assign launch_chan = i_cfg.auto_scan
		? next_chan(o_mux_chan, i_scan_mask) : i_fixed_chan;

	// conversion may only begin once the settle count is spent
	assign o_conv_start = (settle_go && wait_zero)
		|| ((st == ssc_settle) && tmr_expire); // RL2 RL19 RL20

	// second reading had inputs swapped, so subtract then halve
	assign chop_diff = {first_read[DATA_W-1], first_read}
		- {i_conv_data[DATA_W-1], i_conv_data};
	assign res_data = chop_run ? chop_diff[DATA_W:1] : i_conv_data; // RL5

	assign o_mux_out_en = 1'b1; // RL10
	assign o_busy = (st != ssc_idle);

	ssc_settle_timer #(
		.CNT_W(CNT_W)
	) u_timer (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_load(tmr_load),
		.i_count(tmr_count),
		.o_busy(),
		.o_expire(tmr_expire)
	);

	always_comb begin
		next_st = st;
		case (st)
			ssc_idle: begin
				if (launch) begin
					next_st = wait_zero ? ssc_conv : ssc_settle;
				end
			end
			ssc_settle: begin
				if (o_conv_start) begin
					next_st = ssc_conv;
				end
			end
			ssc_conv: begin
				if (swap_evt) begin
					next_st = wait_zero ? ssc_conv : ssc_settle;
				end else if (res_fire) begin
					next_st = ovh_zero ? ssc_idle : ssc_post;
				end
			end
			ssc_post: begin
				if (tmr_expire) begin
					next_st = ssc_idle;
				end
			end
			default: next_st = ssc_idle;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
			start_lvl <= 1'b0;
		end else if (i_ce) begin
			sync1 <= i_start_pin;
			sync2 <= sync1;
			sync3 <= sync2;
			if (sync2 == sync3) begin
				start_lvl <= sync3;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st <= ssc_idle;
			chop_run <= 1'b0;
			chop_phase <= 1'b0;
			o_polarity_swap <= 1'b0;
			o_mux_chan <= 4'hF;
			first_read <= '0;
		end else if (i_ce) begin
			st <= next_st;
			if (launch) begin
				o_mux_chan <= launch_chan;
				chop_run <= i_cfg.ext_chop_enable;
				chop_phase <= 1'b0;
				o_polarity_swap <= 1'b0;
			end else if (swap_evt) begin
				first_read <= i_conv_data;
				chop_phase <= 1'b1;
				o_polarity_swap <= 1'b1; // RL4 RL7
			end else if (res_fire) begin
				chop_phase <= 1'b0;
				o_polarity_swap <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_result <= '0;
			o_data_ready_n <= 1'b1;
			data_ready_n_pend <= 1'b0;
		end else if (i_ce) begin
			if (res_fire) begin
				o_result.data <= res_data; // RL5 RL6
				o_result.chan <= o_mux_chan;
				o_data_ready_n <= 1'b1;
				data_ready_n_pend <= 1'b1;
			end else if (data_ready_n_pend) begin
				// a read in this cycle loses to the fresh result
				o_data_ready_n <= 1'b0; // RL18
				data_ready_n_pend <= 1'b0;
			end else if (i_data_read) begin
				o_data_ready_n <= 1'b1;
			end
		end
	end

	// bias follows the mux output, so unselected inputs never see it
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_adc_internal <= 1'b1;
			o_bias_src_pos <= 1'b0;
			o_bias_sink_neg <= 1'b0;
			o_bias_high <= 1'b0;
			o_rate_select <= '0;
		end else if (i_ce) begin
			o_adc_internal <= !i_cfg.loop_bypass_sel; // RL9
			o_bias_src_pos <= i_cfg.bias_enable; // RL11 RL12
			o_bias_sink_neg <= i_cfg.bias_enable; // RL11 RL12
			o_bias_high <= i_cfg.bias_high; // RL11
			o_rate_select <= i_cfg.rate_select;
		end
	end

	// assertion helpers
	logic [CNT_W-1:0] settle_seen;
	logic [CNT_W-1:0] held_target;
	logic [1:0] starts_seen;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			settle_seen <= '0;
			held_target <= '0;
			starts_seen <= '0;
		end else if (i_ce) begin
			if (settle_go) begin
				settle_seen <= '0;
				held_target <= wait_cnt;
			end else if (st == ssc_settle) begin
				settle_seen <= settle_seen + CNT_W'(1);
			end
			if (res_fire) begin
				starts_seen <= '0;
			end else if (o_conv_start) begin
				starts_seen <= starts_seen + 2'h1;
			end
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_data_ready_n_pulse;
		o_data_ready_n ##1 !o_data_ready_n;
	endsequence

	sequence s_result_taken;
		res_fire ##1 i_ce;
	endsequence

	property p_settle_len; // RL1
		(st == ssc_settle) && o_conv_start
			|-> settle_seen == held_target - CNT_W'(1);
	endproperty
	a_settle_len: assert property (p_settle_len) // RL1
		else $error("settle wait length wrong");

	property p_nonzero_wait; // RL3
		settle_go && !wait_zero |-> !o_conv_start ##1 st == ssc_settle;
	endproperty
	a_nonzero_wait: assert property (p_nonzero_wait) // RL3
		else $error("non-zero delay did not hold off conversion");

	property p_zero_wait; // RL20
		settle_go && wait_zero |-> o_conv_start;
	endproperty
	a_zero_wait: assert property (p_zero_wait) // RL20
		else $error("zero delay did not start at once");

	property p_fixed_nochop; // RL17
		launch && !i_cfg.auto_scan && !i_cfg.ext_chop_enable
			|-> o_conv_start;
	endproperty
	a_fixed_nochop: assert property (p_fixed_nochop) // RL17
		else $error("fixed mode without chop waited");

	property p_chop_swap; // RL4
		swap_evt |=> o_polarity_swap && o_mux_chan == $past(o_mux_chan);
	endproperty
	a_chop_swap: assert property (p_chop_swap) // RL4
		else $error("chop second phase not swapped on same channel");

	property p_chop_half; // RL6
		res_fire |-> starts_seen == (chop_run ? 2'h2 : 2'h1);
	endproperty
	a_chop_half: assert property (p_chop_half) // RL6
		else $error("conversions per result wrong");

	property p_data_ready_n; // RL18
		s_result_taken |-> s_data_ready_n_pulse;
	endproperty
	a_data_ready_n: assert property (p_data_ready_n) // RL18
		else $error("data ready not asserted after result");

	property p_bypass; // RL9
		i_ce |=> o_adc_internal == !$past(i_cfg.loop_bypass_sel);
	endproperty
	a_bypass: assert property (p_bypass) // RL9
		else $error("bypass routing wrong");

	property p_mux_active; // RL10
		o_mux_out_en && (o_bias_src_pos == o_bias_sink_neg);
	endproperty
	a_mux_active: assert property (p_mux_active) // RL10
		else $error("mux outputs inactive or bias pair split");
endmodule : ssc_sequencer

/* File: verification/ssc_conv_model.sv */
// converter partner: answers each start after a set latency
`timescale 1ns/100ps
module ssc_conv_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_start,
	input wire logic i_swap,
	input wire logic [3:0] i_chan,
	input wire logic [3:0] i_lat,
	output logic o_done,
	output logic [23:0] o_data
);
	logic [3:0] cnt;
	logic [23:0] pat = 24'h00_0000;
	logic [23:0] s;
	logic [23:0] v;
	logic fin;
	assign s = {4'h0, i_chan, 16'h0100};
	// fixed offset cancels only when swapped reading is averaged
	assign v = i_swap ? 24'h00_0040 - s : s + 24'h00_0040;
	// mux and polarity move at the start edge, so read them at the end
	assign fin = !i_rst && !i_start && (cnt == 4'h1);
	always @(posedge i_clk) begin
		pat <= pat + 24'h00_0001;
		o_done <= fin;
		// stale data never holds still between answers
		o_data <= fin ? v : ~pat;
		if (i_rst) begin
			cnt <= 4'h0;
		end else if (i_start) begin
			cnt <= i_lat;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end
endmodule : ssc_conv_model

/* File: verification/ssc_sequencer_tb.sv */
// self-checking bench for the scan, settle and chop sequencer
`timescale 1ns/100ps
module ssc_sequencer_tb;
	import ssc_pkg::*;
	localparam int U = 4;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	ssc_cfg_s cfg;
	logic [15:0] mask;
	logic [3:0] fch, lat, mch, ch;
	logic pin, pcmd, rd, cs, done, swp, men, aint, bsp, bsn, bhi, drn, busy;
	logic [23:0] cdat;
	logic [1:0] rate;
	ssc_result_s res;
	int mismatches = 0;
	int cmp_count = 0;
	int starts = 0;
	int cyc = 0;
	int d0, d, g, g0, s0;
	int units [8] = '{0, 1, 2, 4, 8, 16, 32, 48};
	always #20 i_clk = ~i_clk;
	// short unit and overhead keep the run brief
	ssc_sequencer #(.UNIT_CLKS(U), .OVH_CLKS(8)) ssc_sequencer_i (
		.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_cfg(cfg),
		.i_scan_mask(mask), .i_fixed_chan(fch), .i_start_pin(pin),
		.i_pulse_cmd(pcmd), .i_data_read(rd), .o_conv_start(cs),
		.i_conv_done(done), .i_conv_data(cdat), .o_mux_chan(mch),
		.o_polarity_swap(swp), .o_mux_out_en(men), .o_adc_internal(aint),
		.o_bias_src_pos(bsp), .o_bias_sink_neg(bsn), .o_bias_high(bhi),
		.o_rate_select(rate), .o_result(res), .o_data_ready_n(drn),
		.o_busy(busy));
	ssc_conv_model ssc_conv_model_i (.i_clk(i_clk), .i_rst(i_rst),
		.i_start(cs), .i_swap(swp), .i_chan(mch), .i_lat(lat),
		.o_done(done), .o_data(cdat));
	task automatic summarize;
		if (mismatches == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	always @(posedge i_clk) begin
		cyc++;
		if (cs === 1'b1)
			starts++;
		if (cyc == 20000) begin
			mismatches++;
			summarize();
		end
	end
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			$display("mismatch %s exp %h seen %h", n, e, s);
			mismatches++;
		end
	endtask : chk
	function automatic logic [23:0] val(input logic [3:0] c);
		return {4'h0, c, 16'h0100};
	endfunction : val
	function automatic logic [3:0] nxt(input logic [3:0] c);
		logic [3:0] n;
		n = c;
		for (int i = 0; i < 16; i++) begin
			n = n + 4'h1;
			if (mask[n])
				return n;
		end
		return c;
	endfunction : nxt
	task automatic hread;
		rd = 1'b1;
		@(negedge i_clk);
		rd = 1'b0;
		@(negedge i_clk);
		chk("data_ready_n_read", 1, drn);
	endtask : hread
	// one launch: wait to first start, second phase, result, idle
	task automatic run(input bit p, input bit chop, output int dd,
		output int gg);
		int t;
		t = 0;
		gg = 0;
		s0 = starts;
		if (p)
			pin = 1'b1;
		else
			pcmd = 1'b1;
		#1;
		while (cs !== 1'b1 && t < 400) begin
			@(negedge i_clk);
			pcmd = 1'b0;
			t++;
		end
		dd = t;
		@(negedge i_clk);
		pcmd = 1'b0;
		// a pin start stays high: only its rise may launch
		while (chop && cs !== 1'b1 && gg < 400) begin
			@(negedge i_clk);
			gg++;
		end
		@(negedge i_clk);
		chk("swap", chop, swp);
		t = 0;
		while (drn !== 1'b0 && t < 400) begin
			@(negedge i_clk);
			t++;
		end
		while (busy !== 1'b0 && t < 800) begin
			@(negedge i_clk);
			t++;
		end
		@(negedge i_clk);
		chk("idle", 0, busy);
	endtask : run
	initial begin
		cfg = '0;
		mask = 16'h8005;
		fch = 4'h5;
		pin = 1'b0;
		pcmd = 1'b0;
		rd = 1'b0;
		lat = 4'h1;
		repeat (8) @(negedge i_clk);
		i_rst = 1'b0;
		chk("mux_rst", 32'h0000_000F, mch);
		chk("data_ready_n_rst", 1, drn);
		chk("busy_rst", 0, busy);
		chk("mux_en", 1, men);
		cfg.auto_scan = 1'b1;
		cfg.pulse_mode = 1'b1;
		cfg.rate_select = 2'b10;
		ch = 4'hF;
		for (int k = 0; k < 8; k++) begin
			cfg.switch_delay_code = k[2:0];
			lat = k[0] ? 4'h6 : 4'h1;
			ch = nxt(ch);
			hread();
			run(0, 0, d, g);
			if (k == 0)
				d0 = d;
			chk("settle", units[k] * U, d - d0);
			chk("chan", ch, res.chan);
			chk("data", val(ch) + 24'h00_0040, res.data);
			chk("starts", 1, starts - s0);
		end
		chk("zero_wait", 0, d0);
		cfg.auto_scan = 1'b0;
		cfg.switch_delay_code = 3'h7;
		cfg.bias_enable = 1'b1;
		cfg.bias_high = 1'b1;
		hread();
		run(0, 0, d, g);
		chk("fixed_wait", d0, d);
		chk("fixed_chan", 5, res.chan);
		chk("internal", 1, aint);
		chk("bias", 3'b111, {bsp, bsn, bhi});
		chk("rate", 2, rate);
		chk("mux_ch", 5, mch);
		cfg.loop_bypass_sel = 1'b1;
		cfg.bias_high = 1'b0;
		hread();
		run(1, 0, d, g);
		// pin held high long after: only its rise may count
		repeat (20) @(negedge i_clk);
		chk("pin_once", 1, starts - s0);
		pin = 1'b0;
		chk("internal", 0, aint);
		chk("mux_en", 1, men);
		chk("bias_low", 3'b110, {bsp, bsn, bhi});
		cfg.bias_enable = 1'b0;
		cfg.ext_chop_enable = 1'b1;
		for (int k = 0; k < 3; k += 2) begin
			cfg.switch_delay_code = k[2:0];
			hread();
			run(0, 1, d, g);
			if (k == 0)
				g0 = g;
			chk("chop_wait", units[k] * U, d - d0);
			chk("chop_gap", units[k] * U, g - g0);
			chk("chop_starts", 2, starts - s0);
			chk("chop_avg", val(4'h5), res.data);
		end
		chk("bias_off", 0, {bsp, bsn});
		cfg.ext_chop_enable = 1'b0;
		summarize();
	end
endmodule : ssc_sequencer_tb
